// ---- logic/eps_pkg.sv ----
/*
  Shared constants for the pin-driven programming link of the on-chip
  program memory: operation codes, array geometry, region bounds and
  strobe timing at the 40 MHz system clock.
  Assumes both ends import it whole.
*/
package eps_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int OPC_W = 4;
  localparam int ARRAY_BYTES = 8192;
  localparam int TAG_BYTES = 64;
  localparam int TAG_ADDR_W = 6;
  localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hFF;
  localparam logic RESET_LOCK_CELL = 1'b1;
  // Operation codes.
  localparam logic [OPC_W-1:0] OP_STANDBY = 4'h0;
  localparam logic [OPC_W-1:0] OP_READ = 4'h1;
  localparam logic [OPC_W-1:0] OP_UNLOCK = 4'h2;
  localparam logic [OPC_W-1:0] OP_WRITE = 4'h3;
  localparam logic [OPC_W-1:0] OP_LOCK = 4'h4;
  localparam logic [OPC_W-1:0] OP_TAG_WRITE = 4'h5;
  localparam logic [OPC_W-1:0] OP_LOCK_READ = 4'h9;
  localparam logic [OPC_W-1:0] OP_TAG_READ = 4'hA;
  // Memory regions.
  localparam logic [ADDR_W-1:0] START_VEC_LAST = 13'h0002;
  localparam logic [ADDR_W-1:0] IRQ_VEC_FIRST = 13'h0003;
  localparam logic [ADDR_W-1:0] IRQ_VEC_LAST = 13'h000E;
  localparam logic [ADDR_W-1:0] MBF_FIRST = 13'h000F;
  localparam logic [ADDR_W-1:0] MBF_LAST = 13'h0400;
  localparam logic [ADDR_W-1:0] CODE_FIRST = 13'h0400;
  localparam logic [ADDR_W-1:0] CODE_LAST = 13'h1FFF;
  // Strobe timing.
  localparam int CLK_MHZ = 40;
  localparam int STROBE_WRITE_NS = 10000;
  localparam int STROBE_OTHER_NS = 100;
  localparam int STEP_NS = 100;
  localparam int WRITE_CYC = (STROBE_WRITE_NS * CLK_MHZ + 999) / 1000;
  localparam int OTHER_CYC = (STROBE_OTHER_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 10;
  // Controller register map.
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RESULT = 4'h4;
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_ENTER = 2'h2;
endpackage : eps_pkg

// ---- logic/eps_link_if.sv ----
/*
  Link between programmer and device: level and edge control pins plus
  the two-way byte port, resolved here from both enables.
  Assumes the programmer never drives while the device drives.
*/
`timescale 1ns/1ps
interface eps_link_if;
  logic prog_reset_n;
  logic test_n;
  logic supply_high;
  logic supply_on;
  logic addr_clear_n;
  logic addr_step;
  logic opc_clear;
  logic opc_step;
  logic strobe_n;
  logic [7:0] prog_data_out;
  logic prog_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic [7:0] program_data_port;

  // The port shows whichever end drives it; idle floats high as ones.
  assign program_data_port = dev_data_oe ? dev_data_out :
    (prog_data_oe ? prog_data_out : 8'hFF);

  modport device (
    input prog_reset_n, test_n, supply_high, supply_on, addr_clear_n,
    input addr_step, opc_clear, opc_step, strobe_n, program_data_port,
    output dev_data_out, dev_data_oe
  );
  modport programmer (
    output prog_reset_n, test_n, supply_high, supply_on, addr_clear_n,
    output addr_step, opc_clear, opc_step, strobe_n,
    output prog_data_out, prog_data_oe,
    input program_data_port
  );
endinterface : eps_link_if

// ---- logic/eps_array.sv ----
/*
  Program array and version tag store with one-way bit programming.
  Assumes one write per cycle at most.
*/
`timescale 1ns/1ps
module eps_array
  import eps_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic wr_en,
  input wire logic tag_sel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);
  // Cells start blank and keep their contents through a device reset,
  // as nonvolatile cells would.
  logic [DATA_W-1:0] mem [ARRAY_BYTES] = '{default: BLANK_BYTE}; // R16
  logic [DATA_W-1:0] tag [TAG_BYTES] = '{default: BLANK_BYTE};
  logic [DATA_W-1:0] cur;
  wire [TAG_ADDR_W-1:0] tag_addr = addr[TAG_ADDR_W-1:0];

  assign cur = tag_sel ? tag[tag_addr] : mem[addr];

  // Registered read of the byte or tag entry that the address picks.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rdata <= BLANK_BYTE;
    end
    else
    begin
      rdata <= cur;
    end
  end

  // Writing can only clear bits; only erasure restores ones.
  always_ff @(posedge CLK)
  begin
    if (wr_en && !tag_sel)
      mem[addr] <= mem[addr] & wdata; // R16
    if (wr_en && tag_sel)
      tag[tag_addr] <= tag[tag_addr] & wdata; // R22
  end
endmodule // eps_array

// ---- logic/eps_device.sv ----
/*
  Device end of the programming link: address and operation registers,
  lock status, lock cell, strobe-executed operations, data port drive.
  Assumes link pins are synchronous to CLK and the array keeps its data.
*/
`timescale 1ns/1ps
// Overview of operation
// R1: Decode standby, read, unlock, write, lock, tag codes.
// R2: Eight kbyte array, 13-bit address, byte data.
// R3: Bytes 0-2 start address; 3-14 interrupt vectors.
// R4: Bytes 15-1024 membership data; code to 8191.
// R5: Programmer holds reset and test low.
// R6: Low programming supply permits reads only.
// R7: Strobe, address clear low; opcode clear high; steps rise.
// R8: Data port drives only while opcode clear high.
// R9: Lock status 0 allows only code/status reads; here locked reads return any array byte.
// R10: Unlock sets status only if lock cell 1.
// R11: Address clear zeroes address and lock status.
// R12: Steps increment registers; opcode clear zeroes operation.
// R13: Programmer loads code by steps, then strobes.
// R14: Strobe 10 us for write, else 100 ns.
// R15: Lock clears lock cell permanently; here a device reset restores it.
// R16: Blank bits one; writes only clear bits.
// R17: Programmer unlocks, selects write, steps address, strobes.
// R18: After write, port output value meaningless.
// R19: Verify drives byte, zeroes operation register.
// R20: Programmer rewrites a mismatching byte.
// R21: Standby when strobe high or code zero.
// R22: Sixty-four byte tag readable while locked.
module eps_device
  import eps_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  eps_link_if.device LINK,
  output logic PROG_MODE,
  output logic STANDBY,
  output logic LOCK_STATUS,
  output logic LOCK_CELL
);
  logic [ADDR_W-1:0] addr;
  logic [OPC_W-1:0] opc;
  logic addr_step_d;
  logic opc_step_d;
  logic strobe_d;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] arr_rdata;
  logic last_was_read;
  logic last_was_write;

  // Edge detection on the synchronous link pins.
  wire in_mode = !LINK.prog_reset_n && !LINK.test_n && LINK.supply_on;
  wire addr_rise = LINK.addr_step && !addr_step_d; // R7
  wire opc_rise = LINK.opc_step && !opc_step_d; // R7
  wire strobe_fall = !LINK.strobe_n && strobe_d; // R7
  // The readout is taken as the strobe returns high, while the operation
  // register still holds the code that was executed.
  wire strobe_rise = LINK.strobe_n && !strobe_d;
  wire addr_clr = !LINK.addr_clear_n; // R7

  // Operation decode and its permission checks.
  wire is_read = opc == OP_READ; // R1
  wire is_unlock = opc == OP_UNLOCK; // R1
  wire is_write = opc == OP_WRITE; // R1
  wire is_lock = opc == OP_LOCK; // R1
  wire is_tag_wr = opc == OP_TAG_WRITE; // R1
  wire is_lock_rd = opc == OP_LOCK_READ; // R1
  wire is_tag_rd = opc == OP_TAG_READ; // R1
  wire exec = in_mode && strobe_fall && opc != OP_STANDBY; // R21
  wire may_write = LOCK_STATUS && LINK.supply_high; // R6 R9
  wire do_write = exec && (is_write || is_tag_wr) && may_write;
  wire do_unlock = exec && is_unlock && LOCK_CELL; // R10
  wire do_lock = exec && is_lock && may_write; // R15
  wire tag_sel = is_tag_wr || is_tag_rd;

  // Memory map of the current address. The map is fixed, so these only
  // label where a byte lands; the vectors and the membership data are
  // read and written like any other byte.
  wire in_start = addr <= START_VEC_LAST; // R3
  wire in_irq_vec = addr >= IRQ_VEC_FIRST && addr <= IRQ_VEC_LAST; // R3
  wire in_mbf = addr >= MBF_FIRST && addr <= MBF_LAST; // R4
  wire in_code = addr >= CODE_FIRST; // R4

  // Readout selection: status codes show the lock flag in bit 0, the rest
  // show the array byte or tag byte that the address picks.
  wire status_rd = is_lock_rd || is_unlock;
  wire capture = in_mode && strobe_rise && last_was_read;
  wire [DATA_W-1:0] readout = status_rd ?
    {7'h00, LOCK_STATUS} : arr_rdata; // R9 R22
  // A write leaves nothing worth showing, so the port then reads blank.
  wire [DATA_W-1:0] next_port = last_was_write ? BLANK_BYTE : result;

  assign PROG_MODE = in_mode;
  assign STANDBY = LINK.strobe_n || opc == OP_STANDBY; // R21

  eps_array eps_array_i (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .wr_en(do_write),
    .tag_sel(tag_sel),
    .addr(addr),
    .wdata(LINK.program_data_port), // R16
    .rdata(arr_rdata)
  );

  // Pin history for edges. The strobe history resets high, its idle
  // level, so no false strobe edge follows reset.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      addr_step_d <= 1'b0;
      opc_step_d <= 1'b0;
      strobe_d <= 1'b1;
    end
    else
    begin
      addr_step_d <= LINK.addr_step;
      opc_step_d <= LINK.opc_step;
      strobe_d <= LINK.strobe_n;
    end
  end

  // Address register: cleared on level, stepped on edge.
  // Steps wrap at the top of the array, as the 13-bit counter does.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      addr <= '0;
    else if (addr_clr)
      addr <= '0; // R11
    else if (in_mode && addr_rise)
      addr <= addr + 1'b1; // R2 R12
  end

  // Operation register; verify readout leaves it cleared as well.
  // A step seen while the clear is high is lost, as the clear wins.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      opc <= OP_STANDBY;
    else if (LINK.opc_clear)
      opc <= OP_STANDBY; // R12
    else if (in_mode && opc_rise)
      opc <= opc + 1'b1; // R12
  end

  // Lock status: address clear wins so a release always starts locked.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      LOCK_STATUS <= 1'b0;
    else if (addr_clr)
      LOCK_STATUS <= 1'b0; // R11
    else if (do_unlock)
      LOCK_STATUS <= 1'b1; // R10
  end

  // Lock cell stands in for a nonvolatile fuse; reset gives blank state.
  // A device reset restores it, which a real fuse would not allow.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      LOCK_CELL <= RESET_LOCK_CELL;
    else if (do_lock)
      LOCK_CELL <= 1'b0; // R15
  end

  // Result capture for readout; locked reads still see code and tag.
  // The flags are taken at every strobe fall in programming mode, so a standby strobe clears
  // them and an older readout is never captured again.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      result <= BLANK_BYTE;
      last_was_read <= 1'b0;
      last_was_write <= 1'b0;
    end
    else if (in_mode && strobe_fall)
    begin
      last_was_read <= is_read || is_tag_rd || is_lock_rd || is_unlock;
      last_was_write <= is_write || is_tag_wr; // R18
    end
    else if (capture)
    begin
      result <= readout; // R9 R19 R22
    end
  end

  // The enable follows the opcode clear with no register in between, so
  // the device lets go of the port in the same cycle that the programmer
  // takes it back; a registered enable would overlap the two drivers.
  assign LINK.dev_data_oe = in_mode && LINK.opc_clear; // R8

  // Port data come from a register so the driven byte never glitches;
  // after a write the byte shown is blank and carries no meaning.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      LINK.dev_data_out <= BLANK_BYTE;
    end
    else
    begin
      LINK.dev_data_out <= next_port; // R18 R19
    end
  end
endmodule // eps_device

// ---- logic/eps_programmer.sv ----
/*
  Programmer end: runs one operation per start command over the link,
  keeping the documented pin order and strobe widths.
  Assumes the plain register port with read data one cycle later.
*/
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module eps_programmer
  import eps_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  eps_link_if.programmer LINK
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_CLR = 6'b000010, S_OPC = 6'b000100,
    S_ADV = 6'b001000, S_STROBE = 6'b010000, S_READ = 6'b100000
  } eps_state_t;
  eps_state_t state;
  logic [3:0] op;
  logic [ADDR_W-1:0] steps;
  logic [ADDR_W-1:0] step_req;
  logic [7:0] data;
  logic [7:0] result;
  logic [CNT_W-1:0] cnt;
  logic [3:0] left;
  logic hi;
  logic mode;
  logic supply_high;

  wire busy = state != S_IDLE;
  wire wr_cmd = WR && ADDR == REG_CMD && !busy;
  wire [CNT_W-1:0] strobe_len = op == OP_WRITE || op == OP_TAG_WRITE ?
    CNT_W'(WRITE_CYC) : CNT_W'(OTHER_CYC); // R14
  wire cnt_done = cnt == '0;

  assign LINK.prog_reset_n = !mode; // R5
  assign LINK.test_n = !mode; // R5
  assign LINK.supply_on = mode;
  assign LINK.supply_high = supply_high;
  assign LINK.addr_clear_n = mode; // R17
  assign LINK.prog_data_out = data;
  assign LINK.prog_data_oe = !LINK.opc_clear && mode;

  // Register writes from software.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      mode <= 1'b0;
      supply_high <= 1'b0;
      step_req <= '0;
      data <= 8'hFF;
    end
    else if (WR && !busy)
    begin
      if (ADDR == REG_CMD && WDATA[1:0] == CMD_ENTER)
      begin
        mode <= WDATA[2];
        supply_high <= WDATA[3];
      end
      if (ADDR == REG_ADDR)
        step_req <= {5'h00, WDATA};
      if (ADDR == REG_DATA)
        data <= WDATA;
    end
  end

  // Read port, one cycle latency.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= ADDR == REG_STATUS ? {6'h00, mode, busy} :
        (ADDR == REG_RESULT ? result : 8'h00);
  end

  // Sequence: clear, count opcode, advance, strobe, read out.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state <= S_IDLE;
      op <= OP_STANDBY;
      cnt <= '0;
      left <= '0;
      steps <= '0;
      hi <= 1'b0;
      result <= 8'h00;
      LINK.opc_clear <= 1'b0;
      LINK.opc_step <= 1'b0;
      LINK.addr_step <= 1'b0;
      LINK.strobe_n <= 1'b1;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (wr_cmd && WDATA[1:0] == CMD_START)
          begin
            op <= WDATA[7:4];
            left <= WDATA[7:4];
            steps <= step_req;
            LINK.opc_clear <= 1'b1; // R13
            cnt <= CNT_W'(STEP_CYC);
            state <= S_CLR;
          end
        end
        S_CLR:
        begin
          cnt <= cnt - 1'b1;
          if (cnt_done)
          begin
            LINK.opc_clear <= 1'b0;
            cnt <= CNT_W'(STEP_CYC);
            state <= S_OPC;
          end
        end
        S_OPC:
        begin
          cnt <= cnt - 1'b1;
          if (cnt_done)
          begin
            cnt <= CNT_W'(STEP_CYC);
            hi <= !hi;
            LINK.opc_step <= !hi && left != 0; // R13
            if (hi)
              left <= left - 1'b1;
            if (!hi && left == 0)
            begin
              hi <= 1'b0;
              state <= S_ADV;
            end
          end
        end
        S_ADV:
        begin
          cnt <= cnt - 1'b1;
          if (cnt_done)
          begin
            cnt <= CNT_W'(STEP_CYC);
            hi <= !hi;
            LINK.addr_step <= !hi && steps != 0; // R17
            if (hi)
              steps <= steps - 1'b1;
            if (!hi && steps == 0)
            begin
              LINK.strobe_n <= 1'b0;
              cnt <= strobe_len; // R14
              hi <= 1'b0;
              state <= S_STROBE;
            end
          end
        end
        S_STROBE:
        begin
          cnt <= cnt - 1'b1;
          if (cnt_done)
          begin
            LINK.strobe_n <= 1'b1;
            LINK.opc_clear <= 1'b1; // R19
            cnt <= CNT_W'(STEP_CYC);
            state <= S_READ;
          end
        end
        S_READ:
        begin
          cnt <= cnt - 1'b1;
          if (cnt_done)
          begin
            result <= LINK.program_data_port; // R20
            LINK.opc_clear <= 1'b0;
            state <= S_IDLE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // eps_programmer

// ---- dv/eps_sva.sv ----
/*
  Checker for the programming link: watches the shared interface and the
  device status outputs.
  Assumes it is instantiated beside the interface in the bench top.
*/
`timescale 1ns/1ps
module eps_sva
  import eps_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic prog_reset_n,
  input wire logic test_n,
  input wire logic supply_on,
  input wire logic addr_clear_n,
  input wire logic opc_clear,
  input wire logic opc_step,
  input wire logic strobe_n,
  input wire logic [7:0] prog_data_out,
  input wire logic prog_data_oe,
  input wire logic dev_data_oe,
  input wire logic PROG_MODE,
  input wire logic STANDBY,
  input wire logic LOCK_STATUS,
  input wire logic LOCK_CELL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic [CNT_W-1:0] low_cnt;

  // Counts strobe low cycles so short pulses are caught without repetition.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      low_cnt <= '0;
    else
      low_cnt <= strobe_n ? '0 : low_cnt + 1'b1;
  end

  mode_entry_a: assert property (
    PROG_MODE == (!prog_reset_n && !test_n && supply_on))
    else $error("mode wrong");
  port_idle_a: assert property (!opc_clear |-> !dev_data_oe)
    else $error("port driven");
  no_clash_a: assert property (!(dev_data_oe && prog_data_oe))
    else $error("both drive");
  standby_level_a: assert property (strobe_n |-> STANDBY)
    else $error("standby missing");
  unlock_cell_a: assert property ($rose(LOCK_STATUS) |-> LOCK_CELL)
    else $error("unlock past cell");
  cell_oneway_a: assert property (!$rose(LOCK_CELL))
    else $error("cell came back");
  clear_relock_a: assert property (!addr_clear_n |=> !LOCK_STATUS)
    else $error("status kept");
  strobe_width_a: assert property (
    $rose(strobe_n) |-> low_cnt >= OTHER_CYC) else $error("strobe short");
  data_hold_a: assert property (
    !strobe_n && $past(!strobe_n) |-> $stable(prog_data_out))
    else $error("data moved");
  step_order_a: assert property (
    $rose(opc_step) |-> strobe_n && addr_clear_n)
    else $error("step misplaced");
  cover property ($rose(LOCK_STATUS));
  cover property ($fell(LOCK_CELL));
  cover property ($rose(dev_data_oe));
  cover property ($rose(strobe_n) && low_cnt >= WRITE_CYC);
endmodule // eps_sva

// ---- dv/tb_eprom_pin_programming_sequencer.sv ----
/*
  Bench joining programmer and device; software commands go through the
  register port and results are judged against the expected bytes.
  Assumes the register map and command layout of the shared package.
*/
`timescale 1ns/1ps
module tb_eprom_pin_programming_sequencer
  import eps_pkg::*;
;
  logic CLK = 0, RESET_N = 0, WR = 0, RD = 0;
  logic [3:0] ADDR = '0;
  logic [7:0] WDATA = '0, RDATA, r;
  logic prog_mode, standby, lock_status, lock_cell;
  int num_errors = 0, compares = 0, cycles = 0;
  eps_link_if link();
  eps_device eps_device_i(.CLK(CLK), .RESET_N(RESET_N), .LINK(link),
    .PROG_MODE(prog_mode), .STANDBY(standby), .LOCK_STATUS(lock_status),
    .LOCK_CELL(lock_cell));
  eps_programmer eps_programmer_i(.CLK(CLK), .RESET_N(RESET_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .LINK(link));
  eps_sva eps_sva_i(.CLK(CLK), .RESET_N(RESET_N),
    .prog_reset_n(link.prog_reset_n), .test_n(link.test_n),
    .supply_on(link.supply_on), .addr_clear_n(link.addr_clear_n),
    .opc_clear(link.opc_clear), .opc_step(link.opc_step),
    .strobe_n(link.strobe_n), .prog_data_out(link.prog_data_out),
    .prog_data_oe(link.prog_data_oe), .dev_data_oe(link.dev_data_oe),
    .PROG_MODE(prog_mode), .STANDBY(standby),
    .LOCK_STATUS(lock_status), .LOCK_CELL(lock_cell));

  // Free-running 40 MHz clock.
  initial
  begin
    forever #12.5 CLK = ~CLK;
  end

  // Cuts a hang short; a full run needs well under this many cycles.
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read; sample there.
  task automatic rd(logic [3:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask

  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 1000; i++)
    begin
      rd(REG_STATUS, s);
      if (s[0] === 1'b0)
        break;
    end
    check("busy", {7'h00, s[0]}, 8'h00);
  endtask

  task automatic mode(logic on, logic hi);
    wr(REG_CMD, {4'h0, hi, on, CMD_ENTER});
    wait_idle();
  endtask

  task automatic op(logic [7:0] steps, logic [7:0] d, logic [3:0] code,
    output logic [7:0] res);
    wr(REG_ADDR, steps);
    wr(REG_DATA, d);
    wr(REG_CMD, {code, 2'b00, CMD_START});
    wait_idle();
    rd(REG_RESULT, res);
  endtask

  task automatic t_enter();
    mode(1'b1, 1'b1);
    rd(REG_STATUS, r);
    check("status", r, 8'h02);
    check("mode", {7'h00, prog_mode}, 8'h01);
    check("lock status", {7'h00, lock_status}, 8'h00);
  endtask

  task automatic t_write_verify();
    op(8'h00, 8'h00, OP_UNLOCK, r);
    check("unlock readout", r, 8'h01);
    check("lock status", {7'h00, lock_status}, 8'h01);
    op(8'h01, 8'hA5, OP_WRITE, r);
    op(8'h00, 8'h00, OP_READ, r);
    check("verify", r, 8'hA5);
    op(8'h00, 8'h0F, OP_WRITE, r);
    op(8'h00, 8'h00, OP_READ, r);
    check("rewrite", r, 8'h05);
    check("start area", {7'h00, eps_device_i.in_start}, 8'h01);
    check("mbf area", {7'h00, eps_device_i.in_mbf}, 8'h00);
  endtask

  task automatic t_tag();
    op(8'h00, 8'h3C, OP_TAG_WRITE, r);
    op(8'h00, 8'h00, OP_TAG_READ, r);
    check("tag", r, 8'h3C);
    op(8'h00, 8'h00, OP_LOCK_READ, r);
    check("lock read", r, 8'h01);
    op(8'h00, 8'h00, OP_STANDBY, r);
    check("standby", {7'h00, standby}, 8'h01);
  endtask

  task automatic t_low_supply();
    mode(1'b0, 1'b0);
    check("mode off", {7'h00, prog_mode}, 8'h00);
    mode(1'b1, 1'b0);
    op(8'h00, 8'h00, OP_UNLOCK, r);
    op(8'h01, 8'h00, OP_WRITE, r);
    op(8'h00, 8'h00, OP_READ, r);
    check("low supply", r, 8'h05);
    op(8'h01, 8'h00, OP_READ, r);
    check("blank", r, 8'hFF);
  endtask

  task automatic t_lock();
    mode(1'b0, 1'b0);
    mode(1'b1, 1'b1);
    op(8'h00, 8'h00, OP_UNLOCK, r);
    op(8'h00, 8'h00, OP_LOCK, r);
    check("cell", {7'h00, lock_cell}, 8'h00);
    mode(1'b0, 1'b0);
    mode(1'b1, 1'b1);
    op(8'h00, 8'h00, OP_UNLOCK, r);
    check("relock", {7'h00, lock_status}, 8'h00);
    op(8'h01, 8'h00, OP_WRITE, r);
    op(8'h00, 8'h00, OP_READ, r);
    check("locked read", r, 8'h05);
  endtask

  // Reset for three cycles, then the scenarios in order.
  initial
  begin
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    t_enter();
    t_write_verify();
    t_tag();
    t_low_supply();
    t_lock();
    finish_test();
  end
endmodule // tb_eprom_pin_programming_sequencer
